//--- core/cio_pkg.sv
// constants shared by the configurable i/o port block
// assumes one 200 MHz core clock and an active-low power-up reset
package cio_pkg;

  // ****************************************************************
  // port widths
  // ****************************************************************
  localparam int BD_W   = 8;  // bidirectional port lines
  localparam int ANA_W  = 4;  // analogue-capable port lines
  localparam int FOUT_W = 8;  // fixed output port lines
  localparam int FIN_W  = 8;  // fixed input port lines, large variant
  localparam int FANA_W = 3;  // fixed analogue port lines, large variant
  localparam int SEL_W  = 3;  // bit select of a per-line request

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] DIR_RST      = 8'h00;  // every line an input
  localparam logic [7:0] VAL_RST      = 8'h00;
  localparam logic [7:0] FOUT_RST     = 8'h00;
  localparam logic [3:0] ANA_MODE_RST = 4'h0;   // every line analogue
  localparam logic [7:0] ALL_OUT      = 8'hff;
  localparam logic [2:0] FANA_ON      = 3'h7;
  localparam logic [2:0] FANA_OFF     = 3'h0;

  // ****************************************************************
  // special-function line positions on the bidirectional port
  // ****************************************************************
  localparam int IR_BIT   = 0;
  localparam int PWM1_BIT = 1;
  localparam int PWM2_BIT = 2;
  localparam int SCL_BIT  = 3;
  localparam int SDA_BIT  = 4;
  localparam int KBC_BIT  = 6;
  localparam int KBD_BIT  = 7;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 5;
  localparam int REFRESH_NS     = 10000;  // direction refresh period
  localparam int REFRESH_CYCLES = REFRESH_NS / CLK_PERIOD_NS;

endpackage : cio_pkg

//--- core/cio_dir_if.sv
// carrier between the port core and the direction refresher
// assumes both ends share one clock
`timescale 1ns/100ps
interface cio_dir_if;
  logic [cio_pkg::BD_W-1:0] cfg_dir;    // maintained direction, 1 = out
  logic                     cfg_load;   // configuration written now
  logic                     poke_wr;    // raw write of hardware setting
  logic [cio_pkg::BD_W-1:0] poke_tris;  // raw value, 1 = input
  logic [cio_pkg::BD_W-1:0] hw_dir;     // hardware direction, 1 = out
  logic                     tick;       // refresh happening now

  modport core    (output cfg_dir, cfg_load, poke_wr, poke_tris,
                   input  hw_dir, tick);
  modport refresh (input  cfg_dir, cfg_load, poke_wr, poke_tris,
                   output hw_dir, tick);
endinterface : cio_dir_if

//--- core/cio_dir_refresh.sv
// hardware direction setting of the bidirectional port and its refresh
// assumes a synchronised active-low reset from the top module
`timescale 1ns/100ps
module cio_dir_refresh #(
  parameter int REFRESH_CYCLES = cio_pkg::REFRESH_CYCLES
) (
  input  wire logic  clk_i,      // core clock
  input  wire logic  rst_n_i,    // synchronised reset, active low
  cio_dir_if.refresh dir_if      // configuration and hardware setting
);

  localparam int CW = $clog2(REFRESH_CYCLES);

  logic [CW-1:0]            cnt_r;
  logic [cio_pkg::BD_W-1:0] hw_dir_r;
  logic                     tick_w;

  assign tick_w      = (cnt_r == CW'(REFRESH_CYCLES - 1));
  assign dir_if.tick = tick_w;
  assign dir_if.hw_dir = hw_dir_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= tick_w ? '0 : cnt_r + 1'b1;
    end
  end

  // RULE8: periodic rewrite from configuration
  // a raw write survives only until the next tick; a configuration write
  // wins over a raw write in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hw_dir_r <= cio_pkg::DIR_RST;
    end else if (dir_if.cfg_load || tick_w) begin
      hw_dir_r <= dir_if.cfg_dir;
    end else if (dir_if.poke_wr) begin
      hw_dir_r <= ~dir_if.poke_tris;
    end
  end

  a_refresh_restore: assert property ( // RULE8
    @(posedge clk_i) disable iff (!rst_n_i)
    tick_w |=> hw_dir_r == $past(dir_if.cfg_dir))
    else $error("hardware direction not restored at refresh");

  a_refresh_period: assert property ( // RULE8
    @(posedge clk_i) disable iff (!rst_n_i)
    tick_w |=> !tick_w && cnt_r == '0)
    else $error("refresh counter did not restart");

endmodule : cio_dir_refresh

//--- core/cio_top.sv
// configurable i/o ports: analogue-capable, fixed output, bidirectional,
// and on the large variant fixed input and fixed analogue ports
// assumes pins arrive asynchronously and control strobes on clk_i
//
// Behaviour
// RULE1: four analogue lines, optionally read digitally
// RULE2: eight fixed outputs, no direction control
// RULE3: eight bidirectional lines, inputs after reset
// RULE4: direction register, one means output
// RULE5: inverted direction view, same lines
// RULE6: set request forces output and level
// RULE7: value write sets all levels at once
// RULE8: hardware direction refreshed from configuration
// RULE9: analogue lines never feed pulse functions
// RULE10: large variant has fixed standard input port
// RULE11: large variant has three fixed analogue lines
// RULE12: small variant special functions take bidir lines
// RULE13: large variant only pwm, i2c on bidir
// RULE14: output value kept while line is input
`timescale 1ns/100ps
module cio_top #(
  parameter bit LARGE_VARIANT  = 1'b0,  // 1 = forty-leg variant
  parameter int REFRESH_CYCLES = cio_pkg::REFRESH_CYCLES
) (
  input  wire logic                       clk_i,            // core clock
  input  wire logic                       reset_n_i,        // async reset
  // analogue-capable port
  input  wire logic [cio_pkg::ANA_W-1:0]  ana_pin_i,        // pin levels
  input  wire logic                       ana_mode_wr_i,    // mode write
  input  wire logic [cio_pkg::ANA_W-1:0]  ana_mode_wdata_i, // 1 = digital
  output logic      [cio_pkg::ANA_W-1:0]  ana_mode_o,       // mode read
  output logic      [cio_pkg::ANA_W-1:0]  ana_conv_en_o,    // to converter
  output logic      [cio_pkg::ANA_W-1:0]  ana_level_o,      // digital read
  // fixed output port
  input  wire logic                       fout_wr_i,        // value write
  input  wire logic [cio_pkg::FOUT_W-1:0] fout_wdata_i,     // new levels
  output logic      [cio_pkg::FOUT_W-1:0] fixed_output_port_o,    // pins
  output logic      [cio_pkg::FOUT_W-1:0] fixed_output_port_oe_o, // enable
  // bidirectional port configuration
  input  wire logic                       dir_wr_i,         // 1 = out view
  input  wire logic [cio_pkg::BD_W-1:0]   dir_wdata_i,      // direction
  input  wire logic                       tris_wr_i,        // 1 = in view
  input  wire logic [cio_pkg::BD_W-1:0]   tris_wdata_i,     // direction
  input  wire logic                       val_wr_i,         // value write
  input  wire logic [cio_pkg::BD_W-1:0]   val_wdata_i,      // levels
  input  wire logic                       set_req_i,        // per-line set
  input  wire logic [cio_pkg::SEL_W-1:0]  set_bit_i,        // line number
  input  wire logic                       set_level_i,      // 1 = high
  input  wire logic                       poke_wr_i,        // raw write
  input  wire logic [cio_pkg::BD_W-1:0]   poke_tris_i,      // 1 = input
  output logic      [cio_pkg::BD_W-1:0]   dir_o,            // 1 = out
  output logic      [cio_pkg::BD_W-1:0]   tris_o,           // 1 = in
  output logic      [cio_pkg::BD_W-1:0]   val_o,            // value read
  output logic      [cio_pkg::BD_W-1:0]   hw_dir_o,         // live setting
  // bidirectional port pins
  input  wire logic [cio_pkg::BD_W-1:0]   bd_pin_i,         // pin levels
  output logic      [cio_pkg::BD_W-1:0]   bd_pin_o,         // drive level
  output logic      [cio_pkg::BD_W-1:0]   bd_pin_oe_o,      // drive enable
  output logic      [cio_pkg::BD_W-1:0]   bd_level_o,       // port read
  // large-variant ports
  input  wire logic [cio_pkg::FIN_W-1:0]  fixed_input_port_i, // pins
  output logic      [cio_pkg::FANA_W-1:0] fixed_analogue_port_en_o, // conv
  // standard input and pulse sources
  output logic      [cio_pkg::FIN_W-1:0]  std_input_o,      // plain read
  output logic      [cio_pkg::FIN_W-1:0]  pulse_src_o,      // count/width
  // special functions
  input  wire logic                       ir_en_i,          // infrared on
  input  wire logic [1:0]                 pwm_en_i,         // pwm 1, 2 on
  input  wire logic [1:0]                 pwm_level_i,      // pwm levels
  input  wire logic                       i2c_setup_function_i, // i2c on
  input  wire logic                       kb_en_i,          // keyboard on
  output logic                            ir_in_o,          // infrared in
  output logic                            i2c_scl_o,        // clock in
  output logic                            i2c_sda_o,        // data in
  output logic                            kb_clk_o,         // keyboard clk
  output logic                            kb_data_o         // keyboard dat
);

  localparam int BW = cio_pkg::BD_W;

  // ****************************************************************
  // reset release and pin synchronisers
  // ****************************************************************
  logic                       rst_meta_r;
  logic                       rst_n;
  logic [BW-1:0]              bd_meta_r;
  logic [BW-1:0]              bd_sync_r;
  logic [cio_pkg::ANA_W-1:0]  ana_meta_r;
  logic [cio_pkg::ANA_W-1:0]  ana_sync_r;
  logic [cio_pkg::FIN_W-1:0]  fin_meta_r;
  logic [cio_pkg::FIN_W-1:0]  fin_sync_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bd_meta_r  <= '0;
      bd_sync_r  <= '0;
      ana_meta_r <= '0;
      ana_sync_r <= '0;
      fin_meta_r <= '0;
      fin_sync_r <= '0;
    end else begin
      bd_meta_r  <= bd_pin_i;
      bd_sync_r  <= bd_meta_r;
      ana_meta_r <= ana_pin_i;
      ana_sync_r <= ana_meta_r;
      fin_meta_r <= fixed_input_port_i;
      fin_sync_r <= fin_meta_r;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [BW-1:0]              dir_r;
  logic [BW-1:0]              dir_nxt;
  logic [BW-1:0]              val_r;
  logic [BW-1:0]              val_nxt;
  logic [cio_pkg::FOUT_W-1:0] fout_r;
  logic [cio_pkg::ANA_W-1:0]  ana_mode_r;
  logic [BW-1:0]              set_mask_w;
  logic [BW-1:0]              dir_base_w;
  logic [BW-1:0]              val_base_w;

  assign set_mask_w = set_req_i ? (BW'(1) << set_bit_i) : '0;
  // RULE4: one selects output
  // RULE5: inverted view writes the same storage
  assign dir_base_w = dir_wr_i  ? dir_wdata_i :
                      tris_wr_i ? ~tris_wdata_i : dir_r;
  // RULE6: set request forces output
  assign dir_nxt    = dir_base_w | set_mask_w;
  // RULE7: all levels at once
  assign val_base_w = val_wr_i ? val_wdata_i : val_r;
  // RULE6: and the requested level
  assign val_nxt    = set_level_i ? (val_base_w | set_mask_w)
                                  : (val_base_w & ~set_mask_w);

  // RULE3: inputs after reset
  // RULE14: value held independent of direction
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= cio_pkg::DIR_RST;
      val_r <= cio_pkg::VAL_RST;
    end else begin
      dir_r <= dir_nxt;
      val_r <= val_nxt;
    end
  end

  // RULE2: value only, no direction state
  // RULE1: analogue after reset
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fout_r     <= cio_pkg::FOUT_RST;
      ana_mode_r <= cio_pkg::ANA_MODE_RST;
    end else begin
      if (fout_wr_i) begin
        fout_r <= fout_wdata_i;
      end
      if (ana_mode_wr_i) begin
        ana_mode_r <= ana_mode_wdata_i;
      end
    end
  end

  assign dir_o                  = dir_r;
  assign tris_o                 = ~dir_r;
  assign val_o                  = val_r;
  assign ana_mode_o             = ana_mode_r;
  assign ana_conv_en_o          = ~ana_mode_r;
  assign fixed_output_port_o    = fout_r;
  // RULE2: permanently driven
  assign fixed_output_port_oe_o = cio_pkg::ALL_OUT;
  // RULE11: fixed analogue on the large variant only
  assign fixed_analogue_port_en_o = LARGE_VARIANT ? cio_pkg::FANA_ON
                                                  : cio_pkg::FANA_OFF;

  // ****************************************************************
  // hardware direction setting
  // ****************************************************************
  cio_dir_if dir_if ();
  logic [BW-1:0] hw_dir_w;

  assign dir_if.cfg_dir   = dir_nxt;
  assign dir_if.cfg_load  = dir_wr_i | tris_wr_i | set_req_i;
  assign dir_if.poke_wr   = poke_wr_i;
  assign dir_if.poke_tris = poke_tris_i;
  assign hw_dir_w         = dir_if.hw_dir;
  assign hw_dir_o         = hw_dir_w;

  cio_dir_refresh #(
    .REFRESH_CYCLES (REFRESH_CYCLES)
  ) u_refresh (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .dir_if  (dir_if.refresh)
  );

  // ****************************************************************
  // special-function takeover of bidirectional lines
  // ****************************************************************
  logic          small_w;
  logic [BW-1:0] sf_take_w;
  logic [BW-1:0] sf_oe_w;
  logic [BW-1:0] sf_out_w;
  logic [BW-1:0] bd_oe_w;
  logic [BW-1:0] bd_out_w;

  assign small_w = !LARGE_VARIANT;
  // RULE12: small variant takes ir and keyboard lines too
  // RULE13: large variant takes only pwm and i2c lines
  assign sf_take_w = {small_w & kb_en_i, small_w & kb_en_i, 1'b0,
                      i2c_setup_function_i, i2c_setup_function_i,
                      pwm_en_i[1], pwm_en_i[0], small_w & ir_en_i};
  assign sf_oe_w   = {5'h00, 2'h3, 1'b0};
  assign sf_out_w  = {5'h00, pwm_level_i[1], pwm_level_i[0], 1'b0};

  // RULE14: stored value reaches the pin once driven
  generate
    for (genvar i = 0; i < BW; i++) begin : g_line
      assign bd_oe_w[i]  = sf_take_w[i] ? sf_oe_w[i]  : hw_dir_w[i];
      assign bd_out_w[i] = sf_take_w[i] ? sf_out_w[i] : val_r[i];
    end
  endgenerate

  // ****************************************************************
  // input views
  // ****************************************************************
  logic [cio_pkg::FIN_W-1:0] std_src_w;
  logic                      ir_src_w;
  logic                      kbc_src_w;
  logic                      kbd_src_w;

  // RULE10: fixed input port is the standard input on large variant
  assign std_src_w = LARGE_VARIANT ? fin_sync_r : bd_sync_r;
  assign ir_src_w  = LARGE_VARIANT ? fin_sync_r[cio_pkg::IR_BIT]
                                   : bd_sync_r[cio_pkg::IR_BIT];
  assign kbc_src_w = LARGE_VARIANT ? fin_sync_r[cio_pkg::KBC_BIT]
                                   : bd_sync_r[cio_pkg::KBC_BIT];
  assign kbd_src_w = LARGE_VARIANT ? fin_sync_r[cio_pkg::KBD_BIT]
                                   : bd_sync_r[cio_pkg::KBD_BIT];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bd_pin_o    <= '0;
      bd_pin_oe_o <= '0;
      bd_level_o  <= '0;
      ana_level_o <= '0;
      std_input_o <= '0;
      pulse_src_o <= '0;
      ir_in_o     <= 1'b0;
      i2c_scl_o   <= 1'b0;
      i2c_sda_o   <= 1'b0;
      kb_clk_o    <= 1'b0;
      kb_data_o   <= 1'b0;
    end else begin
      bd_pin_o    <= bd_out_w;
      bd_pin_oe_o <= bd_oe_w;
      bd_level_o  <= bd_sync_r;
      // RULE1: digital read only where selected
      ana_level_o <= ana_sync_r & ana_mode_r;
      std_input_o <= std_src_w;
      // RULE9: pulse functions never see the analogue port
      pulse_src_o <= std_src_w;
      ir_in_o     <= ir_src_w & ir_en_i;
      i2c_scl_o   <= bd_sync_r[cio_pkg::SCL_BIT] & i2c_setup_function_i;
      i2c_sda_o   <= bd_sync_r[cio_pkg::SDA_BIT] & i2c_setup_function_i;
      kb_clk_o    <= kbc_src_w & kb_en_i;
      kb_data_o   <= kbd_src_w & kb_en_i;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_dir_write: assert property ( // RULE4
    @(posedge clk_i) disable iff (!rst_n)
    dir_wr_i && !set_req_i |=> dir_o == $past(dir_wdata_i))
    else $error("direction write not stored");

  a_tris_view: assert property ( // RULE5
    @(posedge clk_i) disable iff (!rst_n)
    tris_wr_i && !dir_wr_i && !set_req_i
      |=> dir_o == ~$past(tris_wdata_i) && tris_o == $past(tris_wdata_i))
    else $error("inverted direction view wrong");

  a_set_request: assert property ( // RULE6
    @(posedge clk_i) disable iff (!rst_n)
    set_req_i |=> dir_o[$past(set_bit_i)] &&
                  val_o[$past(set_bit_i)] == $past(set_level_i))
    else $error("set request did not drive line");

  a_val_write: assert property ( // RULE7
    @(posedge clk_i) disable iff (!rst_n)
    val_wr_i && !set_req_i |=> val_o == $past(val_wdata_i))
    else $error("value write not stored");

  a_fout_fixed: assert property ( // RULE2
    @(posedge clk_i) disable iff (!rst_n)
    fout_wr_i |=> fixed_output_port_o == $past(fout_wdata_i) &&
                  fixed_output_port_oe_o == cio_pkg::ALL_OUT)
    else $error("fixed output port misbehaved");

  a_pin_follow: assert property ( // RULE14
    @(posedge clk_i) disable iff (!rst_n)
    sf_take_w == '0 |=> bd_pin_oe_o == $past(hw_dir_w) &&
                        bd_pin_o == $past(val_r))
    else $error("pin does not follow value and direction");

  a_reset_state: assert property ( // RULE3
    @(posedge clk_i) disable iff (!rst_n)
    $rose(rst_n) |-> dir_o == cio_pkg::DIR_RST &&
                     ana_conv_en_o == ~cio_pkg::ANA_MODE_RST)
    else $error("wrong state after reset");

  a_pwm_take: assert property ( // RULE13
    @(posedge clk_i) disable iff (!rst_n)
    pwm_en_i[0] |=> bd_pin_oe_o[cio_pkg::PWM1_BIT] &&
                    bd_pin_o[cio_pkg::PWM1_BIT] == $past(pwm_level_i[0]))
    else $error("pwm did not take its line");

  a_std_input: assert property ( // RULE10
    @(posedge clk_i) disable iff (!rst_n)
    ##1 std_input_o == $past(std_src_w) && pulse_src_o == std_input_o)
    else $error("standard input source wrong");

  a_fixed_ana: assert property ( // RULE11
    @(posedge clk_i) disable iff (!rst_n)
    fixed_analogue_port_en_o == (LARGE_VARIANT ? cio_pkg::FANA_ON
                                               : cio_pkg::FANA_OFF))
    else $error("fixed analogue lines wrong");

endmodule : cio_top

//--- verif/tb.sv
// self-checking bench for the configurable i/o port block, both variants
// assumes the port core of core/ with a shortened direction refresh
`timescale 1ns/100ps
module tb;
  localparam int RC = 16;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic [3:0] ana_pin_i, ana_mode_wdata_i, ana_mode_o, ana_conv_en_o;
  logic [3:0] ana_level_o;
  logic [7:0] fout_wdata_i, fixed_output_port_o, fixed_output_port_oe_o;
  logic [7:0] dir_wdata_i, tris_wdata_i, val_wdata_i, poke_tris_i;
  logic [7:0] dir_o, tris_o, val_o, hw_dir_o, bd_pin_i, bd_pin_o;
  logic [7:0] bd_pin_oe_o, bd_level_o, fixed_input_port_i;
  logic [7:0] std_input_o, pulse_src_o;
  logic [2:0] set_bit_i, fixed_analogue_port_en_o;
  logic [1:0] pwm_en_i, pwm_level_i;
  logic       ana_mode_wr_i, fout_wr_i, dir_wr_i, tris_wr_i, val_wr_i;
  logic       set_req_i, set_level_i, poke_wr_i, ir_en_i, kb_en_i;
  logic       i2c_setup_function_i, ir_in_o, i2c_scl_o, i2c_sda_o;
  logic       kb_clk_o, kb_data_o, seen;
  logic [7:0] l_std, l_pulse, l_oe;
  logic [2:0] l_fana;
  logic       l_ir, l_kbc, l_kbd;
  int         err_total = 0;
  int         total_checks = 0;
  int         dir_m, val_m, fout_m, mode_m, n;

  cio_top #(.LARGE_VARIANT(1'b0), .REFRESH_CYCLES(RC)) dut (
    .clk_i, .reset_n_i, .ana_pin_i, .ana_mode_wr_i, .ana_mode_wdata_i,
    .fout_wr_i, .fout_wdata_i, .dir_wr_i, .dir_wdata_i, .tris_wr_i,
    .tris_wdata_i, .val_wr_i, .val_wdata_i, .set_req_i, .set_bit_i,
    .set_level_i, .poke_wr_i, .poke_tris_i, .bd_pin_i, .fixed_input_port_i,
    .ir_en_i, .pwm_en_i, .pwm_level_i, .i2c_setup_function_i, .kb_en_i,
    .ana_mode_o, .ana_conv_en_o, .ana_level_o, .fixed_output_port_o,
    .fixed_output_port_oe_o, .dir_o, .tris_o, .val_o, .hw_dir_o, .bd_pin_o,
    .bd_pin_oe_o, .bd_level_o, .fixed_analogue_port_en_o, .std_input_o,
    .pulse_src_o, .ir_in_o, .i2c_scl_o, .i2c_sda_o, .kb_clk_o, .kb_data_o);

  // same stimulus into a forty-leg core; only its variant outputs are kept
  cio_top #(.LARGE_VARIANT(1'b1), .REFRESH_CYCLES(RC)) dut_large (
    .clk_i, .reset_n_i, .ana_pin_i, .ana_mode_wr_i, .ana_mode_wdata_i,
    .fout_wr_i, .fout_wdata_i, .dir_wr_i, .dir_wdata_i, .tris_wr_i,
    .tris_wdata_i, .val_wr_i, .val_wdata_i, .set_req_i, .set_bit_i,
    .set_level_i, .poke_wr_i, .poke_tris_i, .bd_pin_i, .fixed_input_port_i,
    .ir_en_i, .pwm_en_i, .pwm_level_i, .i2c_setup_function_i, .kb_en_i,
    .ana_mode_o(), .ana_conv_en_o(), .ana_level_o(),
    .fixed_output_port_o(), .fixed_output_port_oe_o(), .dir_o(), .tris_o(),
    .val_o(), .hw_dir_o(), .bd_pin_o(), .bd_pin_oe_o(l_oe), .bd_level_o(),
    .fixed_analogue_port_en_o(l_fana), .std_input_o(l_std),
    .pulse_src_o(l_pulse), .ir_in_o(l_ir), .i2c_scl_o(), .i2c_sda_o(),
    .kb_clk_o(l_kbc), .kb_data_o(l_kbd));

  always #2.5 clk_i = ~clk_i;

  // ****************************************************************
  // checking and driving
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_regs;
    chk("dir", 8'(dir_m), dir_o);
    chk("tris", 8'(~dir_m), tris_o);
    chk("val", 8'(val_m), val_o);
    chk("hw_dir", 8'(dir_m), hw_dir_o);
    chk("pin_oe", 8'(dir_m), bd_pin_oe_o);
    chk("pin", 8'(val_m & dir_m), bd_pin_o & bd_pin_oe_o);
    chk("fout", 8'(fout_m), fixed_output_port_o);
    chk("fout_oe", 8'hff, fixed_output_port_oe_o);
    chk("mode", 8'(mode_m), {4'h0, ana_mode_o});
    chk("conv", 8'(~mode_m & 15), {4'h0, ana_conv_en_o});
  endtask : chk_regs

  // called at a falling edge; one strobe cycle, then one more falling edge to settle
  task automatic wr(input int op, input logic [7:0] d);
    case (op)
      0: begin
        dir_wr_i = 1'b1;
        dir_wdata_i = d;
        dir_m = d;
      end
      1: begin
        tris_wr_i = 1'b1;
        tris_wdata_i = d;
        dir_m = ~d & 255;
      end
      2: begin
        val_wr_i = 1'b1;
        val_wdata_i = d;
        val_m = d;
      end
      3: begin
        set_req_i = 1'b1;
        set_bit_i = d[2:0];
        set_level_i = d[7];
        dir_m = dir_m | (1 << d[2:0]);
        val_m = d[7] ? val_m | (1 << d[2:0]) : val_m & ~(1 << d[2:0]);
      end
      4: begin
        fout_wr_i = 1'b1;
        fout_wdata_i = d;
        fout_m = d;
      end
      default: begin
        ana_mode_wr_i = 1'b1;
        ana_mode_wdata_i = d[3:0];
        mode_m = d & 15;
      end
    endcase
    @(negedge clk_i);
    {dir_wr_i, tris_wr_i, val_wr_i, set_req_i, fout_wr_i} = 5'h0;
    ana_mode_wr_i = 1'b0;
    @(negedge clk_i);
  endtask : wr

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    void'($urandom(55557));
    {ana_pin_i, ana_mode_wdata_i, fout_wdata_i, dir_wdata_i} = '0;
    {tris_wdata_i, val_wdata_i, poke_tris_i, bd_pin_i} = '0;
    {fixed_input_port_i, set_bit_i, pwm_en_i, pwm_level_i} = '0;
    {ana_mode_wr_i, fout_wr_i, dir_wr_i, tris_wr_i, val_wr_i} = '0;
    {set_req_i, set_level_i, poke_wr_i, ir_en_i, kb_en_i} = '0;
    i2c_setup_function_i = 1'b0;
    {dir_m, val_m, fout_m, mode_m} = '0;
    repeat (3) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk_regs;
    chk("fana_en", 8'h00, {5'h0, fixed_analogue_port_en_o});
    chk("fana_l", 8'h07, {5'h0, l_fana});
    wr(2, 8'hff);
    chk_regs;
    wr(0, 8'hff);
    chk_regs;
    wr(2, 8'h00);
    chk_regs;
    wr(1, 8'hff);
    chk_regs;
    wr(3, 8'ha5);
    chk_regs;
    for (int i = 0; i < 40; i++) begin
      wr($urandom % 6, 8'($urandom));
      chk_regs;
    end
    // raw write is overwritten by refresh
    // held two edges: a refresh tick may swallow one of them, never both
    poke_tris_i = 8'(~dir_m) ^ 8'h3c;
    poke_wr_i = 1'b1;
    @(negedge clk_i);
    seen = (hw_dir_o === ~poke_tris_i);
    @(negedge clk_i);
    seen = seen | (hw_dir_o === ~poke_tris_i);
    poke_wr_i = 1'b0;
    chk("poke", 8'h01, {7'h0, seen});
    n = 0;
    while (hw_dir_o !== 8'(dir_m) && n < RC + 4) begin
      @(negedge clk_i);
      n++;
    end
    chk("refresh", 8'(dir_m), hw_dir_o);
    // pins sampled, analogue lines only plain reads
    for (int i = 0; i < 8; i++) begin
      wr(5, 8'($urandom));
      bd_pin_i = 8'($urandom);
      ana_pin_i = 4'($urandom);
      fixed_input_port_i = 8'($urandom);
      repeat (4) @(negedge clk_i);
      chk("level", bd_pin_i, bd_level_o);
      chk("std_in", bd_pin_i, std_input_o);
      chk("pulse", bd_pin_i, pulse_src_o);
      chk("std_in_l", fixed_input_port_i, l_std);
      chk("pulse_l", fixed_input_port_i, l_pulse);
      chk("ana", 8'(ana_pin_i & mode_m), {4'h0, ana_level_o});
    end
    wr(0, 8'hff);
    {ir_en_i, i2c_setup_function_i, kb_en_i} = 3'h7;
    pwm_en_i = 2'h3;
    pwm_level_i = 2'h2;
    bd_pin_i = 8'hd9;
    fixed_input_port_i = 8'hc1;
    repeat (4) @(negedge clk_i);
    chk("sf_in", 8'h1f, {3'h0, ir_in_o, i2c_scl_o, i2c_sda_o,
                         kb_clk_o, kb_data_o});
    chk("sf_oe", 8'h26, bd_pin_oe_o);
    chk("pwm", 8'h04, bd_pin_o & 8'h06);
    chk("sf_dir", 8'hff, dir_o);
    chk("sf_in_l", 8'h07, {5'h0, l_ir, l_kbc, l_kbd});
    chk("sf_oe_l", 8'he7, l_oe);
    end_sim;
  end

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_sim;
  end
endmodule : tb
